// ### ast_defs.svh
// register offsets, field positions, reset values and timing limits of the serial unit
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
`define AST_ADDR_MODE   4'h0
`define AST_ADDR_ERRST  4'h1
`define AST_ADDR_TXST   4'h2
`define AST_ADDR_RXBUF  4'h3
`define AST_ADDR_TXBUF  4'h4
`define AST_ADDR_CKSEL  4'h5
`define AST_ADDR_BRG    4'h6
`define AST_ADDR_IRQST  4'h7
`define AST_ADDR_IRQMSK 4'h8
`define AST_MODE_POWER  7
`define AST_MODE_TXE    6
`define AST_MODE_RXE    5
`define AST_MODE_PS_HI  4
`define AST_MODE_PS_LO  3
`define AST_MODE_CL     2
`define AST_MODE_SL     1
`define AST_MODE_ISRM   0
`define AST_ERR_PE      2
`define AST_ERR_FE      1
`define AST_ERR_OVE     0
`define AST_TXST_BF     1
`define AST_TXST_SF     0
`define AST_IRQ_RX      0
`define AST_IRQ_ERR     1
`define AST_IRQ_TX      2
`define AST_MODE_RST    8'h01
`define AST_CKSEL_RST   4'h0
`define AST_BRG_RST     8'hff
`define AST_IRQMSK_RST  3'h0
`define AST_TPS_MAX     4'ha
`define AST_DIV_MIN     8'h04
`endif

// ### ast_pkg.sv
// types shared by the serial unit modules
package ast_pkg;
  typedef enum logic [2:0] {
    AST_RX_IDLE,
    AST_RX_START,
    AST_RX_DATA,
    AST_RX_PAR,
    AST_RX_STOP
  } ast_rx_state_t;
  typedef enum logic [1:0] {
    AST_PAR_NONE,
    AST_PAR_ZERO,
    AST_PAR_ODD,
    AST_PAR_EVEN
  } ast_par_t;
endpackage

// ### ast_baud_if.sv
// control and tick signals between a shifter and its baud generator
interface ast_baud_if;
  logic       run;
  logic       restart;
  logic [3:0] tps;
  logic [7:0] div;
  logic       half_tick;
  modport ctrl (output run, output restart, output tps, output div, input half_tick);
  modport gen  (input run, input restart, input tps, input div, output half_tick);
endinterface

// ### ast_baud_gen.sv
// prescaler and 8-bit divisor counter giving half-bit ticks
`include "ast_defs.svh"
module ast_baud_gen (
  input  wire logic   i_clk,
  input  wire logic   i_sys_rst,
  ast_baud_if.gen     bd
);
  logic [10:0] pcnt;
  logic [10:0] pmask;
  logic [3:0]  tps_c;
  logic        base_tick;
  logic [7:0]  dcnt;
  logic [7:0]  div_eff;
  logic        div_end;

  // base clock is the system clock divided by two to the power tps, with tps capped at 10
  always_comb
  begin
    tps_c     = (bd.tps > `AST_TPS_MAX) ? `AST_TPS_MAX : bd.tps;
    pmask     = ~(11'h7ff << tps_c);
    base_tick = (pcnt & pmask) == pmask;
    div_eff   = (bd.div < `AST_DIV_MIN) ? `AST_DIV_MIN : bd.div; // tiny divisors cannot sample
    div_end   = base_tick && (dcnt == div_eff - 8'h01);
  end

  // prescale counter, held at zero while stopped so every frame starts in phase
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !bd.run || bd.restart)
      pcnt <= 11'h000;
    else
      pcnt <= pcnt + 11'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !bd.run || bd.restart)
      dcnt <= 8'h00;
    else if (div_end)
      dcnt <= 8'h00;
    else if (base_tick)
      dcnt <= dcnt + 8'h01;
  end

  // half-bit tick at twice the baud rate; the shifters halve it to baud
  // combinational, so the first tick after a restart is not one clock late
  always_comb
  begin
    bd.half_tick = !i_sys_rst && bd.run && !bd.restart && div_end;
  end
endmodule

// ### ast_serial_unit.sv
// asynchronous serial transceiver: registers, receiver, transmitter, interrupt
`include "ast_defs.svh"
module ast_serial_unit (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_serial_rx_pin,
  output logic      [7:0] o_rdata,
  output logic            o_txd,
  output logic            o_irq
);
  logic [7:0]             operation_mode_reg;
  logic [3:0]             clock_select_reg;
  logic [7:0]             baud_gen_control_reg;
  logic [2:0]             irq_mask;
  logic [2:0]             irq_stat;
  logic                   parity_error_flag;
  logic                   frame_err_flag;
  logic                   overrun_flag;
  logic [7:0]             receive_buffer;
  logic                   rx_full;
  logic [7:0]             transmit_buffer;
  logic                   tx_buffer_full_flag;
  logic                   tx_shift_busy_flag;
  ast_pkg::ast_rx_state_t rx_state;
  logic                   rx_ph;
  logic [3:0]             rx_cnt;
  logic [7:0]             rx_sh;
  logic                   rx_acc;
  logic                   rx_pe;
  logic                   rx_fin;
  logic [7:0]             rx_word;
  logic                   rx_fin_pe;
  logic                   rx_fin_fe;
  logic [11:0]            tx_sh;
  logic [3:0]             tx_left;
  logic                   tx_ph;
  logic                   tx_done;
  logic                   unit_power_bit;
  logic                   tx_enable_bit;
  logic                   rx_enable_bit;
  logic                   char_length_select;
  logic                   tx_stop_count_select;
  logic                   error_irq_mode_bit;
  ast_pkg::ast_par_t      par_mode;
  logic                   rx_on;
  logic                   tx_on;
  logic                   wr_mode;
  logic                   wr_tx;
  logic                   rd_err;
  logic                   rd_rxb;
  logic                   rd_irq;
  logic                   rx_tick;
  logic                   rx_smp;
  logic                   rx_discard;
  logic                   rx_load;
  logic                   tx_load;
  logic [7:0]             tx_data;
  logic                   tx_par;
  logic [11:0]            tx_frame;
  logic [3:0]             tx_bits;
  logic [2:0]             next_irq_stat;

  ast_baud_if rx_bd ();
  ast_baud_if tx_bd ();

  ast_baud_gen u_rx_baud (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .bd        (rx_bd)
  );

  ast_baud_gen u_tx_baud (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .bd        (tx_bd)
  );

  // mode fields and decoded bus strobes
  always_comb
  begin
    unit_power_bit       = operation_mode_reg[`AST_MODE_POWER];
    tx_enable_bit        = operation_mode_reg[`AST_MODE_TXE];
    rx_enable_bit        = operation_mode_reg[`AST_MODE_RXE];
    char_length_select   = operation_mode_reg[`AST_MODE_CL];
    tx_stop_count_select = operation_mode_reg[`AST_MODE_SL];
    error_irq_mode_bit   = operation_mode_reg[`AST_MODE_ISRM];
    par_mode = ast_pkg::ast_par_t'(operation_mode_reg[`AST_MODE_PS_HI:`AST_MODE_PS_LO]);
    wr_mode  = i_wr && (i_addr == `AST_ADDR_MODE);
    wr_tx    = i_wr && (i_addr == `AST_ADDR_TXBUF);
    rd_err   = i_rd && (i_addr == `AST_ADDR_ERRST);
    rd_rxb   = i_rd && (i_addr == `AST_ADDR_RXBUF);
    rd_irq   = i_rd && (i_addr == `AST_ADDR_IRQST);
  end

  always_comb
  begin
    tx_on = unit_power_bit && tx_enable_bit;
    rx_on = unit_power_bit && rx_enable_bit;
  end

  // software-written configuration; power, enables and formats live here
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      operation_mode_reg   <= `AST_MODE_RST;
      clock_select_reg     <= `AST_CKSEL_RST;
      baud_gen_control_reg <= `AST_BRG_RST;
      irq_mask             <= `AST_IRQMSK_RST;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `AST_ADDR_MODE:   operation_mode_reg   <= i_wdata;
        `AST_ADDR_CKSEL:  clock_select_reg     <= i_wdata[3:0];
        `AST_ADDR_BRG:    baud_gen_control_reg <= i_wdata;
        `AST_ADDR_IRQMSK: irq_mask             <= i_wdata[2:0];
        default:          irq_mask             <= irq_mask;
      endcase
    end
  end

  // baud generator hookup; rx counter is held in restart while idle
  // divisor shared by both
  always_comb
  begin
    rx_bd.run     = rx_on;
    rx_bd.restart = (rx_state == ast_pkg::AST_RX_IDLE);
    rx_bd.tps     = clock_select_reg;
    rx_bd.div     = baud_gen_control_reg;
    tx_bd.run     = tx_on && tx_shift_busy_flag;
    tx_bd.restart = tx_load;
    tx_bd.tps     = clock_select_reg;
    tx_bd.div     = baud_gen_control_reg;
    rx_tick       = rx_bd.half_tick;
    rx_smp        = rx_tick && rx_ph;
  end

  // receive state machine; level, not edge, starts a frame
  always_ff @(posedge i_clk)
  begin
    rx_fin <= 1'b0;
    if (i_sys_rst || !rx_on)
    begin
      rx_state  <= ast_pkg::AST_RX_IDLE;
      rx_ph     <= 1'b0;
      rx_cnt    <= 4'h0;
      rx_sh     <= 8'h00;
      rx_acc    <= 1'b0;
      rx_pe     <= 1'b0;
      rx_word   <= 8'h00;
      rx_fin_pe <= 1'b0;
      rx_fin_fe <= 1'b0;
    end
    else
    begin
      if (rx_tick)
        rx_ph <= ~rx_ph;
      case (rx_state)
        ast_pkg::AST_RX_IDLE:
        begin
          rx_ph  <= 1'b0;
          rx_cnt <= 4'h0;
          rx_acc <= 1'b0;
          rx_pe  <= 1'b0;
          if (!i_serial_rx_pin)
            rx_state <= ast_pkg::AST_RX_START;
        end
        ast_pkg::AST_RX_START:
        begin
          // mid start bit; a glitch that went high again is dropped
          if (rx_tick)
          begin
            rx_ph    <= 1'b0;
            rx_state <= i_serial_rx_pin ? ast_pkg::AST_RX_IDLE : ast_pkg::AST_RX_DATA;
          end
        end
        ast_pkg::AST_RX_DATA:
        begin
          if (rx_smp)
          begin
            rx_sh  <= {i_serial_rx_pin, rx_sh[7:1]};
            rx_acc <= rx_acc ^ i_serial_rx_pin;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == (char_length_select ? 4'h7 : 4'h6))
              rx_state <= (par_mode == ast_pkg::AST_PAR_NONE) ?
                          ast_pkg::AST_RX_STOP : ast_pkg::AST_RX_PAR;
          end
        end
        ast_pkg::AST_RX_PAR:
        begin
          if (rx_smp)
          begin
            case (par_mode)
              ast_pkg::AST_PAR_ODD:  rx_pe <= ~(rx_acc ^ i_serial_rx_pin);
              ast_pkg::AST_PAR_EVEN: rx_pe <= rx_acc ^ i_serial_rx_pin;
              default:               rx_pe <= 1'b0;
            endcase
            rx_state <= ast_pkg::AST_RX_STOP;
          end
        end
        ast_pkg::AST_RX_STOP:
        begin
          if (rx_smp)
          begin
            rx_fin    <= 1'b1;
            rx_fin_pe <= rx_pe;
            rx_fin_fe <= !i_serial_rx_pin;
            rx_word   <= char_length_select ? rx_sh : {1'b0, rx_sh[7:1]};
            rx_state  <= ast_pkg::AST_RX_IDLE;
          end
        end
        default: rx_state <= ast_pkg::AST_RX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    rx_discard = rx_fin && (rx_full || overrun_flag);
    rx_load    = rx_fin && !rx_discard;
  end

  // receive buffer; a read empties it, a fresh load in the same cycle wins
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !unit_power_bit)
    begin
      receive_buffer <= 8'h00;
      rx_full        <= 1'b0;
    end
    else if (rx_load)
    begin
      receive_buffer <= rx_word;
      rx_full        <= 1'b1;
    end
    else if (rd_rxb)
      rx_full <= 1'b0;
  end

  // reception error flags: cleared by reading them, a new error wins
  // read clears flags
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !unit_power_bit)
    begin
      parity_error_flag <= 1'b0;
      frame_err_flag    <= 1'b0;
      overrun_flag      <= 1'b0;
    end
    else
    begin
      if (rd_err)
      begin
        parity_error_flag <= 1'b0;
        frame_err_flag    <= 1'b0;
        overrun_flag      <= 1'b0;
      end
      if (rx_load && rx_fin_pe)
        parity_error_flag <= 1'b1;
      if (rx_load && rx_fin_fe)
        frame_err_flag <= 1'b1;
      if (rx_discard)
        overrun_flag <= 1'b1;
    end
  end

  // transmit frame: start, data lsb first, parity, stop ones
  always_comb
  begin
    tx_data = char_length_select ? transmit_buffer : {1'b0, transmit_buffer[6:0]};
    case (par_mode)
      ast_pkg::AST_PAR_ODD:  tx_par = ~(^tx_data);
      ast_pkg::AST_PAR_EVEN: tx_par = ^tx_data;
      ast_pkg::AST_PAR_ZERO: tx_par = 1'b0;
      default:               tx_par = 1'b1;
    endcase
    if (char_length_select)
      tx_frame = {2'b11, tx_par, tx_data, 1'b0};
    else
      tx_frame = {3'b111, tx_par, tx_data[6:0], 1'b0};
    tx_bits = (char_length_select ? 4'h9 : 4'h8)
            + ((par_mode == ast_pkg::AST_PAR_NONE) ? 4'h0 : 4'h1)
            + (tx_stop_count_select ? 4'h2 : 4'h1);
    tx_load = tx_on && tx_buffer_full_flag && !tx_shift_busy_flag;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !tx_on)
    begin
      transmit_buffer     <= 8'h00;
      tx_buffer_full_flag <= 1'b0;
    end
    else if (wr_tx)
    begin
      transmit_buffer     <= i_wdata;
      tx_buffer_full_flag <= 1'b1;
    end
    else if (tx_load)
      tx_buffer_full_flag <= 1'b0;
  end

  // transmit shifter; each bit lasts two half-bit ticks
  // busy while shifting
  always_ff @(posedge i_clk)
  begin
    tx_done <= 1'b0;
    if (i_sys_rst || !tx_on)
    begin
      tx_sh              <= 12'hfff;
      tx_left            <= 4'h0;
      tx_ph              <= 1'b0;
      tx_shift_busy_flag <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_sh              <= tx_frame;
      tx_left            <= tx_bits;
      tx_ph              <= 1'b0;
      tx_shift_busy_flag <= 1'b1;
    end
    else if (tx_bd.half_tick)
    begin
      tx_ph <= ~tx_ph;
      if (tx_ph)
      begin
        tx_sh   <= {1'b1, tx_sh[11:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
        begin
          tx_shift_busy_flag <= 1'b0;
          tx_done            <= 1'b1;
        end
      end
    end
  end

  // line idles high whenever the shifter is not busy
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_txd <= 1'b1;
    else
      o_txd <= tx_shift_busy_flag ? tx_sh[0] : 1'b1;
  end

  // interrupt sources; error mode chooses a separate error bit or the rx bit
  always_comb
  begin
    next_irq_stat = rd_irq ? 3'h0 : irq_stat;
    if (tx_done)
      next_irq_stat[`AST_IRQ_TX] = 1'b1;
    if (rx_load && !(rx_fin_pe || rx_fin_fe))
      next_irq_stat[`AST_IRQ_RX] = 1'b1;
    if ((rx_load && (rx_fin_pe || rx_fin_fe)) || rx_discard)
    begin
      if (error_irq_mode_bit)
        next_irq_stat[`AST_IRQ_ERR] = 1'b1;
      else
        next_irq_stat[`AST_IRQ_RX] = 1'b1;
    end
  end

  // sticky status; a set in the clearing cycle survives
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_stat <= 3'h0;
    else
      irq_stat <= next_irq_stat;
  end

  // level interrupt, registered one cycle behind the status
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_stat & irq_mask);
  end

  // read data for one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_rd)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        `AST_ADDR_MODE:   o_rdata <= operation_mode_reg;
        `AST_ADDR_ERRST:  o_rdata <= {5'h00, parity_error_flag, frame_err_flag, overrun_flag};
        `AST_ADDR_TXST:   o_rdata <= {6'h00, tx_buffer_full_flag, tx_shift_busy_flag};
        `AST_ADDR_RXBUF:  o_rdata <= receive_buffer;
        `AST_ADDR_CKSEL:  o_rdata <= {4'h0, clock_select_reg};
        `AST_ADDR_BRG:    o_rdata <= baud_gen_control_reg;
        `AST_ADDR_IRQST:  o_rdata <= {5'h00, irq_stat};
        `AST_ADDR_IRQMSK: o_rdata <= {5'h00, irq_mask};
        default:          o_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ### ast_serial_unit_monitor.sv
// concurrent checks on the serial unit ports, bound to the serial unit
`include "ast_defs.svh"
module ast_serial_unit_monitor (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_serial_rx_pin,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_txd,
  input  wire logic       o_irq
);
  logic [7:0] brg_s;
  logic [3:0] tps_s;
  logic       pwr_s;
  logic [2:0] msk_s;
  int         low_cnt;
  int         bit_t;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // shadow of what software wrote; the checker cannot see inside the unit
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      brg_s <= `AST_BRG_RST;
      tps_s <= `AST_CKSEL_RST;
      pwr_s <= 1'b0;
      msk_s <= `AST_IRQMSK_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == `AST_ADDR_BRG) brg_s <= i_wdata;
      if (i_addr == `AST_ADDR_CKSEL) tps_s <= i_wdata[3:0];
      if (i_addr == `AST_ADDR_MODE) pwr_s <= i_wdata[`AST_MODE_POWER];
      if (i_addr == `AST_ADDR_IRQMSK) msk_s <= i_wdata[2:0];
    end
  end

  // length of the current low run on the transmit line
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst) low_cnt <= 0;
    else low_cnt <= o_txd ? 0 : low_cnt + 1;
  end

  // clocks per bit; small settings are clamped the same way as in the unit
  always_comb
  begin
    bit_t = 2 * ((brg_s < `AST_DIV_MIN) ? int'(`AST_DIV_MIN) : int'(brg_s))
              * (1 << ((tps_s > `AST_TPS_MAX) ? int'(`AST_TPS_MAX) : int'(tps_s)));
  end

  sequence s_mode_wr;
    i_wr && (i_addr == `AST_ADDR_MODE);
  endsequence
  sequence s_mode_rd;
    i_rd && (i_addr == `AST_ADDR_MODE);
  endsequence

  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 4'h8 |-> o_rdata == 8'h00)
    else $error("unmapped index read not zero");
  chk_mode_readback: assert property (s_mode_wr ##1 s_mode_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("mode register read back differs");
  chk_txst_upper: assert property ($past(i_rd) && $past(i_addr) == `AST_ADDR_TXST
                                   |-> o_rdata[7:2] == 6'h00)
    else $error("transmit status upper bits set");
  chk_errst_upper: assert property ($past(i_rd) && $past(i_addr) == `AST_ADDR_ERRST
                                    |-> o_rdata[7:3] == 5'h00)
    else $error("error status upper bits set");
  chk_irq_masked: assert property ($past(msk_s) == 3'h0 |-> !o_irq)
    else $error("interrupt raised with all sources masked");
  chk_txd_unpowered: assert property (!$past(pwr_s) && !$past(pwr_s, 2) |-> o_txd)
    else $error("transmit line low while unit unpowered");
  chk_tx_bit_time: assert property ($rose(o_txd) |-> (low_cnt % bit_t) == 0)
    else $error("transmit low time not a whole number of bits");
  chk_rx_unpowered: assert property (i_rd && i_addr == `AST_ADDR_RXBUF && !pwr_s && !$past(pwr_s)
                                     |=> o_rdata == 8'h00)
    else $error("receive buffer not empty while unpowered");
endmodule
bind ast_serial_unit ast_serial_unit_monitor mon (
  .i_clk           (i_clk),
  .i_sys_rst       (i_sys_rst),
  .i_addr          (i_addr),
  .i_wdata         (i_wdata),
  .i_wr            (i_wr),
  .i_rd            (i_rd),
  .i_serial_rx_pin (i_serial_rx_pin),
  .o_rdata         (o_rdata),
  .o_txd           (o_txd),
  .o_irq           (o_irq)
);

// ### ast_remote_node.sv
// remote serial node: drives the receive line and decodes the transmit line
module ast_remote_node #(
  parameter int BT = 8
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] shf;

  // line idles high, as an undriven serial line with pull-up would
  initial o_line = 1'b1;

  // one frame: start, nb bits lsb first, one stop level, then a bit of idle
  task automatic send(input logic [8:0] bits, input int nb, input logic stop_lvl);
    o_line <= 1'b0;
    repeat (BT) @(posedge i_clk);
    for (int i = 0; i < nb; i++)
    begin
      o_line <= bits[i];
      repeat (BT) @(posedge i_clk);
    end
    o_line <= stop_lvl;
    repeat (BT) @(posedge i_clk);
    o_line <= 1'b1;
    repeat (BT) @(posedge i_clk);
  endtask

  // sample mid bit; a byte without a high stop bit is dropped, so it shows as missing
  always
  begin
    @(negedge i_txd);
    repeat (BT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(posedge i_clk);
      shf[i] = i_txd;
    end
    repeat (BT) @(posedge i_clk);
    if (i_txd) got.push_back(shf);
  end
endmodule

// ### testbench.sv
// self-checking bench for the serial unit: register tasks, serial frames, verdict
`include "ast_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 8;
  logic       i_clk;
  logic       i_sys_rst;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       rx_line;
  logic [7:0] o_rdata;
  logic       o_txd;
  logic       o_irq;
  logic [7:0] rv;
  int         num_errors;
  int         checks;
  int         cycles;
  logic [3:0] ra [5] = '{`AST_ADDR_MODE, `AST_ADDR_CKSEL, `AST_ADDR_BRG, `AST_ADDR_IRQMSK, 4'hf};
  logic [7:0] re [5] = '{`AST_MODE_RST, {4'h0, `AST_CKSEL_RST}, `AST_BRG_RST,
                         {5'h0, `AST_IRQMSK_RST}, 8'h00};
  logic [1:0] pt [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  logic       pb [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] pe [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};

  ast_serial_unit DUT (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .i_serial_rx_pin (rx_line),
    .o_rdata         (o_rdata),
    .o_txd           (o_txd),
    .o_irq           (o_irq)
  );
  ast_remote_node #(.BT(BT)) node (
    .i_clk  (i_clk),
    .i_txd  (o_txd),
    .o_line (rx_line)
  );

  // 10 MHz base clock from a stable source, not a ring oscillator
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hung handshake would otherwise run forever
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    // a strobe lowered in this time step waits one edge before rising again
    if (i_wr)
      @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    d = o_rdata;
  endtask

  // error status is read before the buffer, as software must
  task automatic check_rx(input logic [7:0] e_err, input logic [7:0] e_dat);
    rd(`AST_ADDR_ERRST, rv);
    chk(rv, e_err, "error status");
    rd(`AST_ADDR_RXBUF, rv);
    chk(rv, e_dat, "received byte");
  endtask

  task automatic rx_frame(input logic [8:0] b, input int nb, input logic stp,
                          input logic [7:0] e_err, input logic [7:0] e_dat);
    node.send(b, nb, stp);
    check_rx(e_err, e_dat);
  endtask

  initial
  begin
    i_sys_rst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    num_errors = 0;
    checks = 0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], rv);
      chk(rv, re[i], "reset value");
    end
    $display("test reset_values done");
    wr(`AST_ADDR_CKSEL, 8'h00);
    wr(`AST_ADDR_BRG, 8'h04);
    // power first, no parity, error mode clear with rx off
    wr(`AST_ADDR_MODE, 8'h84);
    rd(`AST_ADDR_MODE, rv);
    chk(rv, 8'h84, "mode read back");
    wr(`AST_ADDR_MODE, 8'he4);
    wr(`AST_ADDR_IRQMSK, 8'h07);
    wr(`AST_ADDR_TXBUF, 8'ha5);
    rd(`AST_ADDR_TXST, rv);
    chk(rv, 8'h02, "first byte waiting");
    // second byte written at once, while the first is shifting
    wr(`AST_ADDR_TXBUF, 8'h3c);
    rd(`AST_ADDR_TXST, rv);
    chk(rv, 8'h03, "both flags set");
    for (int n = 0; n < 300 && rv[1] !== 1'b0; n++) rd(`AST_ADDR_TXST, rv);
    chk(rv, 8'h01, "shifter busy only");
    for (int n = 0; n < 300 && rv[0] !== 1'b0; n++) rd(`AST_ADDR_TXST, rv);
    chk(rv, 8'h00, "transmitter idle");
    repeat (2) @(posedge i_clk);
    chk({7'h0, o_irq}, 8'h01, "completion interrupt");
    rd(`AST_ADDR_IRQST, rv);
    chk(rv, 8'h04, "transmit event");
    repeat (2) @(posedge i_clk);
    chk({7'h0, o_irq}, 8'h00, "interrupt cleared by read");
    chk(8'(node.got.size()), 8'h02, "bytes on the line");
    chk(node.got[0], 8'ha5, "first byte on line");
    chk(node.got[1], 8'h3c, "second byte on line");
    $display("test continuous_tx done");
    wr(`AST_ADDR_IRQMSK, 8'h00);
    rx_frame(9'h05a, 8, 1'b1, 8'h00, 8'h5a);
    chk({7'h0, o_irq}, 8'h00, "masked event");
    wr(`AST_ADDR_IRQMSK, 8'h07);
    repeat (2) @(posedge i_clk);
    chk({7'h0, o_irq}, 8'h01, "unmasked event");
    rd(`AST_ADDR_IRQST, rv);
    chk(rv, 8'h01, "receive event");
    rx_frame(9'h0a5, 8, 1'b0, 8'h02, 8'ha5);
    node.send(9'h011, 8, 1'b1);
    rx_frame(9'h022, 8, 1'b1, 8'h01, 8'h11);
    rx_frame(9'h033, 8, 1'b1, 8'h00, 8'h33);
    $display("test receive_errors done");
    // enables off around every format change; two tx stop bits
    wr(`AST_ADDR_MODE, 8'h84);
    for (int i = 0; i < 5; i++)
    begin
      wr(`AST_ADDR_MODE, 8'h87 | {3'h0, pt[i], 3'h0});
      wr(`AST_ADDR_MODE, 8'he7 | {3'h0, pt[i], 3'h0});
      rx_frame({pb[i], 8'h5a}, (pt[i] == 2'h0) ? 8 : 9, 1'b1, pe[i], 8'h5a);
      wr(`AST_ADDR_MODE, 8'h87 | {3'h0, pt[i], 3'h0});
    end
    rd(`AST_ADDR_IRQST, rv);
    chk(rv, 8'h03, "parity errors on the error source");
    $display("test parity_modes done");
    // seven-bit characters; the line is already low when reception is enabled
    wr(`AST_ADDR_MODE, 8'h80);
    wr(`AST_ADDR_MODE, 8'hc0);
    fork
      node.send(9'h016, 7, 1'b1);
      wr(`AST_ADDR_MODE, 8'he0);
    join
    check_rx(8'h00, 8'h16);
    $display("test enable_on_low done");
    wr(`AST_ADDR_MODE, 8'h80);
    wr(`AST_ADDR_MODE, 8'h00);
    rd(`AST_ADDR_TXST, rv);
    chk(rv, 8'h00, "flags after power off");
    rd(`AST_ADDR_ERRST, rv);
    chk(rv, 8'h00, "errors after power off");
    rd(`AST_ADDR_RXBUF, rv);
    chk(rv, 8'h00, "buffer after power off");
    $display("test power_off done");
    summarize();
  end
endmodule
